// ### logic/frmc_pkg.sv
package frmc_pkg;
   // Timing: core clock and counter reference
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned REF_HZ = 2_000_000;
   localparam int unsigned REF_DIV = CLK_HZ / REF_HZ;
   localparam logic [5:0] REF_DIV_M1 = 6'(REF_DIV - 1);
   // Overload persistence and its error code
   localparam logic [7:0] OVLD_CYCLES = 8'h80;
   localparam logic [7:0] ERR_OVLD_CODE = 8'h1f;
   // Special function numbers
   localparam logic [6:0] SF_GAIN = 7'h03;
   localparam logic [6:0] SF_RANGE = 7'h37;
   localparam logic [6:0] SF_COARSE = 7'h38;
   localparam logic [6:0] SF_FINE = 7'h39;
   localparam logic [3:0] GAIN_FRAC_MAX = 4'h4;
   localparam logic [1:0] GAIN_MAX = 2'h3;
   // Command characters
   localparam logic [7:0] CH_S = 8'h53;
   localparam logic [7:0] CH_P = 8'h50;
   localparam logic [7:0] CH_R = 8'h52;
   localparam logic [7:0] CH_F = 8'h46;
   localparam logic [7:0] CH_DOT = 8'h2e;
   localparam logic [3:0] CH_DIGIT_HI = 4'h3;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   // Tuning sequence
   localparam logic [3:0] TUNE_HDR = 4'h3;
   localparam logic [2:0] TUNE_LAST = 3'h4;
   // Record encoding
   localparam logic [8:0] CLK_BIAS = 9'h104;
   localparam logic [7:0] CYC_BIAS = 8'hff;
   localparam logic [18:0] GATE_MIN_CLK = 19'h01400;
   localparam logic [18:0] CLK_MAX = 19'h413ff;
   localparam logic [11:0] CYC_MAX = 12'hfff;
   localparam logic [2:0] REC_BYTES = 3'h4;
   // APB map
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_TUNE = 8'h08;
   localparam logic [7:0] OFS_RDBK = 8'h0c;
   localparam int CTRL_AUTO_BIT = 0;
   localparam int CTRL_ERRCLR_BIT = 1;
   typedef enum logic [1:0] {LD_FREQ, LD_ECHO, LD_DASH5} frmc_left_t;
   typedef enum logic [1:0] {PS_IDLE, PS_S, PS_R} frmc_pstate_t;
   typedef struct packed {logic [18:0] clocks; logic [11:0] cycles;} frmc_cnt_res_t;
   typedef struct packed {logic [3:0] range; logic [7:0] coarse; logic [7:0] fine;} frmc_tune_t;
endpackage

// ### logic/frmc_recip_counter.sv
`timescale 1ns/10ps
`default_nettype none
module frmc_recip_counter (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic sig_rise,
   output frmc_pkg::frmc_cnt_res_t res,
   output logic res_valid
);
   logic [5:0] pre_q;
   logic gate_q;
   logic [18:0] clocks_q;
   logic [11:0] cycles_q;
   // Reference tick, clock step and cycle step
   wire tick = pre_q == frmc_pkg::REF_DIV_M1;
   wire [18:0] clk_nx = (tick && clocks_q != frmc_pkg::CLK_MAX) ? clocks_q + 19'h00001 : clocks_q;
   wire [11:0] cyc_nx = (cycles_q != frmc_pkg::CYC_MAX) ? cycles_q + 12'h001 : cycles_q;
   wire gate_done = gate_q && sig_rise && clocks_q >= frmc_pkg::GATE_MIN_CLK;

   // Reciprocal count: reference ticks over whole input cycles
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pre_q <= 6'h00;
         gate_q <= 1'b0;
         clocks_q <= 19'h00000;
         cycles_q <= 12'h000;
         res <= '0;
         res_valid <= 1'b0;
      end else begin
         pre_q <= tick ? 6'h00 : pre_q + 6'h01;
         res_valid <= run && gate_done;
         if (run && gate_done) begin
            res <= '{clocks: clocks_q, cycles: cyc_nx};
         end
         if (!run) begin
            gate_q <= 1'b0;
         end else if (sig_rise && (!gate_q || gate_done)) begin
            gate_q <= 1'b1;
            clocks_q <= 19'h00000;
            cycles_q <= 12'h000;
         end else if (gate_q) begin
            clocks_q <= clk_nx;
            cycles_q <= sig_rise ? cyc_nx : cycles_q;
         end
      end
   end
endmodule
`default_nettype wire

// ### logic/frmc_tune_loader.sv
`timescale 1ns/10ps
`default_nettype none
module frmc_tune_loader (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic byte_valid,
   input wire logic [7:0] byte_in,
   output frmc_pkg::frmc_tune_t tune,
   output logic load
);
   logic [2:0] idx_q;
   frmc_pkg::frmc_tune_t acc_q;
   wire hdr_ok = byte_in[7:4] == frmc_pkg::TUNE_HDR;
   wire [3:0] nib = byte_in[3:0];

   // Collects coarse lo/hi, fine lo/hi, then range
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         idx_q <= 3'h0;
         acc_q <= '0;
         tune <= '0;
         load <= 1'b0;
      end else begin
         load <= byte_valid && !clear && hdr_ok && idx_q == frmc_pkg::TUNE_LAST;
         if (clear || (byte_valid && !hdr_ok)) begin
            idx_q <= 3'h0;
         end else if (byte_valid) begin
            unique case (idx_q)
               3'h0: acc_q.coarse[3:0] <= nib;
               3'h1: acc_q.coarse[7:4] <= nib;
               3'h2: acc_q.fine[3:0] <= nib;
               3'h3: acc_q.fine[7:4] <= nib;
               default: tune <= '{range: nib, coarse: acc_q.coarse, fine: acc_q.fine};
            endcase
            idx_q <= (idx_q == frmc_pkg::TUNE_LAST) ? 3'h0 : idx_q + 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### logic/frmc_ctrl.sv
// Summary of operation
// - Manual post-notch gain is one of four values, 0 to 60 dB in 20 dB steps.
// - Code 3.0 selects automatic gain; 3.1 to 3.4 fix gain, applied on terminator.
// - In automatic mode the block picks the post-notch gain itself.
// - Automatic gain is selected after reset and on the automatic-operation command.
// - Codes 3.1 to 3.4 light the special-function lamp; 3.0 leaves it.
// - Entered digits echo on the left display until the terminator.
// - Post-notch overload shows four dashes on the right display.
// - Overload lasting 128 consecutive measurement cycles raises error 31.
// - No error is raised for a manual gain without real overload.
// - Fast count mode streams four-byte counter records until it ends.
// - Any received byte or bus command ends fast count mode.
// - The two-letter fast count code enters fast count mode.
// - Records go out as raw bytes with no delimiters.
// - Clock count packs as low, second, high digit plus 1024 times 260 minus byte one.
// - Cycle count is byte four low nibble plus 16 times 255 minus byte three.
// - Frequency is reciprocal: 2 MHz clocks counted over whole input cycles.
// - Fast count mode shows five dashes on the left display.
// - In fast tune mode five tuning bytes are applied directly.
// - Each tuning byte carries 0011 in its upper nibble; data in the lower.
// - Codes 55., 56., 57. read back range, coarse and fine settings.
// - Codes 55.0, 56.0, 57.0 write zero into that setting.
// - Fast tune starts on its code; key press or attention ends it.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module frmc_ctrl (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic bus_atn_pin,
   input wire logic panel_key_pin,
   input wire logic ovld_pin,
   input wire logic under_pin,
   input wire logic sig_in_pin,
   input wire logic meas_cycle,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   output logic [1:0] gain_sel,
   output logic gain_auto,
   output logic special_function_key_led,
   output frmc_pkg::frmc_left_t left_disp,
   output logic [11:0] echo_digits,
   output logic right_dashes,
   output logic [7:0] error_code,
   output frmc_pkg::frmc_tune_t tune,
   output logic fast_count_mode,
   output logic fast_tune_mode
);
   // Pack a counter result into the four-byte record
   function automatic logic [31:0] pack_rec(input frmc_pkg::frmc_cnt_res_t r);
      logic [8:0] b1;
      logic [7:0] b3;
      b1 = frmc_pkg::CLK_BIAS - r.clocks[18:10];
      b3 = frmc_pkg::CYC_BIAS - r.cycles[11:4];
      pack_rec = {b1[7:0], r.clocks[3:0], r.clocks[7:4], b3, 2'h0, r.clocks[9:8], r.cycles[3:0]};
   endfunction

   // Decimal accumulate of one entered digit
   function automatic logic [6:0] dec_acc(input logic [6:0] v, input logic [3:0] d);
      logic [10:0] t;
      t = {4'h0, v} * 11'h00a + {7'h00, d};
      dec_acc = t[6:0];
   endfunction

   // Two-flop synchronisers for pins: atn, key, ovld, under, sig
   logic [4:0] sync1_q, sync2_q, sync3_q;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
         sync3_q <= 5'h00;
      end else begin
         sync1_q <= {sig_in_pin, under_pin, ovld_pin, panel_key_pin, bus_atn_pin};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end
   wire atn_rise = sync2_q[0] && !sync3_q[0];
   wire key_rise = sync2_q[1] && !sync3_q[1];
   wire ovld_s = sync2_q[2];
   wire under_s = sync2_q[3];
   wire sig_rise = sync2_q[4] && !sync3_q[4];

   // Command parser state
   frmc_pkg::frmc_pstate_t pstate_q;
   logic [6:0] int_q;
   logic dot_q, frac_seen_q, entry_q;
   logic [3:0] frac_q;
   logic fc_mode_q, ft_mode_q;

   // Character classification and command decode
   wire rx_cmd = rx_valid && !ft_mode_q;
   wire is_digit = rx_byte[7:4] == frmc_pkg::CH_DIGIT_HI && rx_byte[3:0] <= frmc_pkg::DIGIT_MAX;
   wire sf_apply = rx_cmd && pstate_q == frmc_pkg::PS_S && rx_byte == frmc_pkg::CH_P;
   wire fc_enter = rx_cmd && pstate_q == frmc_pkg::PS_R && rx_byte == frmc_pkg::CH_F;
   wire ft_enter = rx_cmd && pstate_q == frmc_pkg::PS_R && rx_byte == frmc_pkg::CH_S;
   wire sf_gain = sf_apply && int_q == frmc_pkg::SF_GAIN && frac_q <= frmc_pkg::GAIN_FRAC_MAX;
   wire gain_auto_cmd = sf_gain && frac_q == 4'h0;
   wire gain_man_cmd = sf_gain && frac_q != 4'h0;
   wire tune_fn = int_q == frmc_pkg::SF_RANGE || int_q == frmc_pkg::SF_COARSE || int_q == frmc_pkg::SF_FINE;
   wire tune_rd = sf_apply && tune_fn && dot_q && !frac_seen_q;
   wire tune_zero = sf_apply && tune_fn && frac_seen_q && frac_q == 4'h0;

   // Parser: digits, point, terminator and two-letter codes
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pstate_q <= frmc_pkg::PS_IDLE;
         int_q <= 7'h00;
         dot_q <= 1'b0;
         frac_seen_q <= 1'b0;
         frac_q <= 4'h0;
         entry_q <= 1'b0;
         echo_digits <= 12'h000;
      end else if (rx_cmd) begin
         if (sf_apply || fc_enter || ft_enter) begin
            pstate_q <= frmc_pkg::PS_IDLE;
            int_q <= 7'h00;
            dot_q <= 1'b0;
            frac_seen_q <= 1'b0;
            frac_q <= 4'h0;
            entry_q <= 1'b0;
            echo_digits <= 12'h000;
         end else if (is_digit) begin
            pstate_q <= frmc_pkg::PS_IDLE;
            if (dot_q) begin
               frac_q <= rx_byte[3:0];
               frac_seen_q <= 1'b1;
            end else begin
               int_q <= dec_acc(int_q, rx_byte[3:0]);
            end
            entry_q <= 1'b1;
            echo_digits <= {echo_digits[7:0], rx_byte[3:0]};
         end else if (rx_byte == frmc_pkg::CH_DOT) begin
            pstate_q <= frmc_pkg::PS_IDLE;
            dot_q <= 1'b1;
            entry_q <= 1'b1;
         end else if (rx_byte == frmc_pkg::CH_S) begin
            pstate_q <= frmc_pkg::PS_S;
         end else if (rx_byte == frmc_pkg::CH_R) begin
            pstate_q <= frmc_pkg::PS_R;
         end else begin
            pstate_q <= frmc_pkg::PS_IDLE;
         end
      end
   end

   // APB decode, zero-wait slave
   wire access = psel && penable;
   wire wr_ctrl = access && pwrite && paddr == frmc_pkg::OFS_CTRL;
   wire auto_op = wr_ctrl && pwdata[frmc_pkg::CTRL_AUTO_BIT];
   wire err_clr = wr_ctrl && pwdata[frmc_pkg::CTRL_ERRCLR_BIT];
   wire mapped = paddr == frmc_pkg::OFS_CTRL || paddr == frmc_pkg::OFS_STATUS ||
                 paddr == frmc_pkg::OFS_TUNE || paddr == frmc_pkg::OFS_RDBK;
   logic [7:0] rdbk_q;
   logic err_q;
   logic [7:0] ovld_cnt_q;
   wire [31:0] status_w = {23'h000000, err_q, fast_tune_mode, fast_count_mode, special_function_key_led, gain_auto, 2'h0, gain_sel};
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = (paddr == frmc_pkg::OFS_STATUS) ? status_w :
                   (paddr == frmc_pkg::OFS_TUNE) ? {12'h000, tune} :
                   (paddr == frmc_pkg::OFS_RDBK) ? {24'h000000, rdbk_q} : 32'h00000000;

   // Gain selection: manual codes, automatic stepping, lamp
   wire [1:0] gain_auto_nx = (ovld_s && gain_sel != 2'h0) ? gain_sel - 2'h1 :
                             (under_s && !ovld_s && gain_sel != frmc_pkg::GAIN_MAX) ? gain_sel + 2'h1 : gain_sel;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gain_auto <= 1'b1;
         gain_sel <= 2'h0;
         special_function_key_led <= 1'b0;
      end else begin
         if (auto_op || gain_auto_cmd) begin
            gain_auto <= 1'b1;
         end else if (gain_man_cmd) begin
            gain_auto <= 1'b0;
            gain_sel <= 2'(frac_q - 4'h1);
         end else if (gain_auto && meas_cycle) begin
            gain_sel <= gain_auto_nx;
         end
         if (gain_man_cmd) begin
            special_function_key_led <= 1'b1;
         end else if (auto_op) begin
            special_function_key_led <= 1'b0;
         end
      end
   end

   // Overload persistence counter and error flag
   wire err_set = meas_cycle && ovld_s && ovld_cnt_q == 8'(frmc_pkg::OVLD_CYCLES - 8'h01);
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ovld_cnt_q <= 8'h00;
         err_q <= 1'b0;
      end else begin
         if (meas_cycle) begin
            ovld_cnt_q <= !ovld_s ? 8'h00 :
                          (ovld_cnt_q == frmc_pkg::OVLD_CYCLES) ? ovld_cnt_q : ovld_cnt_q + 8'h01;
         end
         if (err_set) begin
            err_q <= 1'b1;
         end else if (err_clr) begin
            err_q <= 1'b0;
         end
      end
   end
   assign error_code = err_q ? frmc_pkg::ERR_OVLD_CODE : 8'h00;
   assign right_dashes = ovld_s;

   // Mode flags: fast count and fast tune
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fc_mode_q <= 1'b0;
         ft_mode_q <= 1'b0;
      end else begin
         if (fc_enter) begin
            fc_mode_q <= 1'b1;
         end else if (rx_valid || atn_rise) begin
            fc_mode_q <= 1'b0;
         end
         if (ft_enter) begin
            ft_mode_q <= 1'b1;
         end else if (key_rise || atn_rise) begin
            ft_mode_q <= 1'b0;
         end
      end
   end
   assign fast_count_mode = fc_mode_q;
   assign fast_tune_mode = ft_mode_q;
   assign left_disp = (fc_mode_q || ft_mode_q) ? frmc_pkg::LD_DASH5 :
                      entry_q ? frmc_pkg::LD_ECHO : frmc_pkg::LD_FREQ;

   // Reciprocal counter runs while fast count is active
   frmc_pkg::frmc_cnt_res_t res;
   logic res_valid;
   frmc_recip_counter u_cnt (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .run(fc_mode_q),
      .sig_rise(sig_rise),
      .res(res),
      .res_valid(res_valid)
   );

   // Record streamer: four raw bytes, nothing in between
   logic [31:0] tx_q;
   logic [2:0] tx_cnt_q;
   wire rec_load = res_valid && fc_mode_q && tx_cnt_q == 3'h0;
   assign tx_valid = tx_cnt_q != 3'h0;
   assign tx_byte = tx_q[31:24];
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tx_q <= 32'h00000000;
         tx_cnt_q <= 3'h0;
      end else if (!fc_mode_q) begin
         tx_cnt_q <= 3'h0;
      end else if (rec_load) begin
         tx_q <= pack_rec(res);
         tx_cnt_q <= frmc_pkg::REC_BYTES;
      end else if (tx_valid && tx_ready) begin
         tx_q <= {tx_q[23:0], 8'h00};
         tx_cnt_q <= tx_cnt_q - 3'h1;
      end
   end

   // Tuning byte collector fed only in fast tune
   frmc_pkg::frmc_tune_t tune_new;
   logic tune_load;
   frmc_tune_loader u_tune (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clear(!ft_mode_q),
      .byte_valid(rx_valid && ft_mode_q),
      .byte_in(rx_byte),
      .tune(tune_new),
      .load(tune_load)
   );

   // Tuning settings: direct load, readback and zeroing
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tune <= '0;
         rdbk_q <= 8'h00;
      end else begin
         if (tune_load) begin
            tune <= tune_new;
         end else if (tune_zero) begin
            if (int_q == frmc_pkg::SF_RANGE) tune.range <= 4'h0;
            if (int_q == frmc_pkg::SF_COARSE) tune.coarse <= 8'h00;
            if (int_q == frmc_pkg::SF_FINE) tune.fine <= 8'h00;
         end
         if (tune_rd) begin
            rdbk_q <= (int_q == frmc_pkg::SF_RANGE) ? {4'h0, tune.range} :
                      (int_q == frmc_pkg::SF_COARSE) ? tune.coarse : tune.fine;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_man_gain_led: assert property (gain_man_cmd |=> special_function_key_led && !gain_auto && gain_sel == $past(frac_q[1:0]) - 2'h1)
      else $error("manual gain code not applied");
   chk_auto_no_led: assert property (gain_auto_cmd && !special_function_key_led |=> gain_auto && !special_function_key_led)
      else $error("code 3.0 changed lamp");
   chk_ovld_error: assert property (err_set |=> error_code == 8'h1f)
      else $error("overload error not raised");
   chk_err_cause: assert property ($rose(err_q) |-> $past(ovld_s && meas_cycle && ovld_cnt_q == 8'h7f))
      else $error("error raised without overload");
   chk_fc_exit: assert property (fc_mode_q && rx_valid && !fc_enter |=> !fc_mode_q ##1 !tx_valid)
      else $error("fast count not ended");
   chk_ft_exit: assert property (ft_mode_q && atn_rise && !ft_enter |=> !ft_mode_q)
      else $error("fast tune not ended on attention");
   chk_left_dash: assert property ((fc_mode_q || ft_mode_q) |-> left_disp == frmc_pkg::LD_DASH5)
      else $error("left display not dashed");
   chk_rec_byte1: assert property (rec_load |=> tx_byte == 8'(9'h104 - $past(res.clocks[18:10])) && tx_valid)
      else $error("record byte one wrong");
   chk_tune_zero: assert property (tune_zero && int_q == frmc_pkg::SF_COARSE && !tune_load |=> tune.coarse == 8'h00)
      else $error("coarse not zeroed");
   chk_gain_hold: assert property (!gain_auto && !gain_man_cmd && !auto_op && !gain_auto_cmd |=> $stable(gain_sel))
      else $error("manual gain drifted");
   chk_lamp_hold: assert property (special_function_key_led && !auto_op |=> special_function_key_led)
      else $error("special function lamp dropped");
   chk_fc_enter: assert property (fc_enter |=> fc_mode_q)
      else $error("fast count not entered");
   chk_ft_key_exit: assert property (ft_mode_q && key_rise && !ft_enter |=> !ft_mode_q)
      else $error("fast tune not ended on key");
endmodule
`default_nettype wire

// ### bench/frmc_host.sv
`timescale 1ns/10ps
`default_nettype none
module frmc_host (
   input wire logic core_clk,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready
);
   int tx_seen = 0;
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b0;
   end
   // Slow reader: accepts a streamed byte only every other cycle
   always @(posedge core_clk) begin
      tx_ready <= ~tx_ready;
      if (tx_valid && tx_ready) begin
         tx_seen <= tx_seen + 1;
      end
   end
   // One byte per strobe; the released line shows the inverse value
   task automatic send(input logic [7:0] b);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_byte <= b;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_byte <= ~b;
   endtask
   task automatic send_str(input string s);
      for (int i = 0; i < s.len(); i++) begin
         send(s[i]);
      end
   endtask
   // Tuning word, sent as five bytes: coarse lo/hi, fine lo/hi, then range
   task automatic tune(input logic [3:0] r, input logic [7:0] c, input logic [7:0] f);
      logic [19:0] nib;
      nib = {c[3:0], c[7:4], f[3:0], f[7:4], r};
      for (int i = 0; i < 5; i++) begin
         send({4'h3, nib[19 - 4 * i -: 4]});
      end
   endtask
endmodule
`default_nettype wire

// ### bench/tb_fast_remote_modes_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_fast_remote_modes_ctrl;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, rx_valid, tx_valid, tx_ready;
   logic [7:0] rx_byte, tx_byte, error_code;
   logic bus_atn_pin = 1'b0;
   logic panel_key_pin = 1'b0;
   logic ovld_pin = 1'b0;
   logic under_pin = 1'b0;
   logic meas_cycle = 1'b0;
   logic [5:0] sig_div = 6'h00;
   logic [1:0] gain_sel;
   logic gain_auto, special_function_key_led, right_dashes, fast_count_mode, fast_tune_mode;
   logic [11:0] echo_digits;
   frmc_pkg::frmc_left_t left_disp;
   frmc_pkg::frmc_tune_t tune;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #5 core_clk = ~core_clk;
   // Input square wave and hang guard
   always @(posedge core_clk) begin
      sig_div <= sig_div + 6'h01;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end
   frmc_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .bus_atn_pin(bus_atn_pin), .panel_key_pin(panel_key_pin),
      .ovld_pin(ovld_pin), .under_pin(under_pin), .sig_in_pin(sig_div[5]), .meas_cycle(meas_cycle),
      .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .gain_sel(gain_sel), .gain_auto(gain_auto),
      .special_function_key_led(special_function_key_led), .left_disp(left_disp), .echo_digits(echo_digits), .right_dashes(right_dashes),
      .error_code(error_code), .tune(tune), .fast_count_mode(fast_count_mode), .fast_tune_mode(fast_tune_mode));
   frmc_host host (.core_clk(core_clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .tx_ready(tx_ready));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Measurement-cycle pulses, then time for the result to land
   task automatic mc(input int n);
      repeat (n) begin
         @(posedge core_clk);
         meas_cycle <= 1'b1;
         @(posedge core_clk);
         meas_cycle <= 1'b0;
      end
      wt(2);
   endtask
   // One register transfer; read data taken at the edge that ends it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      logic [31:0] e;
      wt(2);
      rst_n <= 1'b1;
      wt(3);
      apb(1'b0, frmc_pkg::OFS_STATUS, 32'h0);
      chk("status", rd, 32'h10);
      apb(1'b0, 8'h10, 32'h0);
      chk("bad_err", err, 1);
      chk("bad_rd", rd, 0);
      under_pin <= 1'b1;
      wt(4);
      mc(2);
      chk("auto_up", gain_sel, 2);
      under_pin <= 1'b0;
      ovld_pin <= 1'b1;
      wt(4);
      mc(1);
      ovld_pin <= 1'b0;
      wt(4);
      mc(1);
      chk("auto_down", gain_sel, 1);
      $display("test reset and auto gain done");
      host.send_str("3.0SP");
      wt(2);
      chk("led_auto", special_function_key_led, 0);
      chk("auto", gain_auto, 1);
      for (int k = 1; k < 5; k++) begin
         host.send_str("3.");
         wt(1);
         chk("echo", left_disp, frmc_pkg::LD_ECHO);
         chk("echo_dig", echo_digits, 12'h003);
         host.send_str($sformatf("%0dSP", k));
         wt(2);
         chk("gain", gain_sel, k - 1);
         chk("manual", gain_auto, 0);
         chk("led", special_function_key_led, 1);
         chk("left", left_disp, frmc_pkg::LD_FREQ);
      end
      $display("test gain codes done");
      ovld_pin <= 1'b1;
      wt(4);
      chk("dashes", right_dashes, 1);
      mc(127);
      chk("err_127", error_code, 0);
      mc(1);
      chk("err_128", error_code, 8'h1f);
      apb(1'b1, frmc_pkg::OFS_CTRL, 32'h2);
      ovld_pin <= 1'b0;
      wt(4);
      chk("no_dashes", right_dashes, 0);
      mc(130);
      chk("err_none", error_code, 0);
      apb(1'b1, frmc_pkg::OFS_CTRL, 32'h1);
      apb(1'b0, frmc_pkg::OFS_STATUS, 32'h0);
      chk("auto_cmd", rd[5:4], 2'b01);
      $display("test overload done");
      for (int x = 0; x < 2; x++) begin
         host.send_str("M146.1SPT3RF");
         wt(2);
         chk("fc_on", fast_count_mode, 1);
         chk("fc_tx", {tx_valid, tx_byte}, 9'h000);
         chk("fc_left", left_disp, frmc_pkg::LD_DASH5);
         if (x == 0) begin
            host.send_str("T");
         end else begin
            bus_atn_pin <= 1'b1;
         end
         wt(5);
         chk("fc_off", fast_count_mode, 0);
         bus_atn_pin <= 1'b0;
      end
      $display("test fast count done");
      host.send_str("RS");
      wt(2);
      chk("ft_on", fast_tune_mode, 1);
      host.send(8'h33);
      host.send(8'h41);
      host.tune(4'h1, 8'h93, 8'h80);
      wt(3);
      chk("tune", tune, 20'h19380);
      apb(1'b0, frmc_pkg::OFS_TUNE, 32'h0);
      chk("tune_reg", rd, 32'h19380);
      host.tune(4'h2, 8'h5a, 8'h0f);
      wt(3);
      chk("retune", tune, 20'h25a0f);
      // Leave fast tune by key, then re-enter and leave by attention
      for (int x = 0; x < 2; x++) begin
         if (x == 0) begin
            panel_key_pin <= 1'b1;
         end else begin
            host.send_str("RS");
            bus_atn_pin <= 1'b1;
         end
         wt(5);
         chk("ft_off", fast_tune_mode, 0);
         panel_key_pin <= 1'b0;
         bus_atn_pin <= 1'b0;
      end
      for (int f = 0; f < 3; f++) begin
         host.send_str($sformatf("5%0d.SP", 5 + f));
         wt(2);
         apb(1'b0, frmc_pkg::OFS_RDBK, 32'h0);
         e = (f == 0) ? 32'h2 : (f == 1) ? 32'h5a : 32'h0f;
         chk("readback", rd, e);
      end
      host.send_str("56.0SP");
      wt(2);
      chk("zeroed", tune, 20'h2000f);
      chk("no_stream", host.tx_seen, 0);
      $display("test fast tune done");
      final_report();
   end
endmodule
`default_nettype wire
